// File: hdl/tcr_axil_slave.sv
/*
 * axi4-lite slave front end: turns reads, and writes with wstrb[0] set, into one-cycle
 * register requests and returns the byte read back in the low lane.
 * assumes rd_data_i is combinational on the request index.
 */
`timescale 1ns/1ps
module tcr_axil_slave (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                arst_n,
    // write address, data and response
    input  wire logic         [11:0] s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic         [31:0] s_axi_wdata,
    input  wire logic          [3:0] s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic               [1:0] s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // read
    input  wire logic         [11:0] s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic              [31:0] s_axi_rdata,
    output logic               [1:0] s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // register side
    output tcr_pkg::tcr_req_t        req_o,
    input  wire logic          [7:0] rd_data_i
);
    logic [7:0]             aw_idx_q;
    logic [7:0]             ar_idx_q;
    logic [7:0]             wdata_q;
    logic                   wlane_q;
    logic                   aw_done_q;
    logic                   w_done_q;
    tcr_pkg::tcr_rd_state_t rd_st_q;
    logic                   do_wr;
    logic                   do_rd;

    assign do_wr = aw_done_q && w_done_q && !s_axi_bvalid;
    assign do_rd = rd_st_q == tcr_pkg::RD_FETCH;

    always_comb begin
        req_o.wr    = do_wr && wlane_q;
        req_o.rd    = do_rd;
        req_o.idx   = do_rd ? ar_idx_q : aw_idx_q;
        req_o.wdata = wdata_q;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_done_q     <= 1'b0;
            w_done_q      <= 1'b0;
            aw_idx_q      <= 8'h00;
            wdata_q       <= 8'h00;
            wlane_q       <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tcr_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx_q      <= s_axi_awaddr[9:2];
                aw_done_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q      <= s_axi_wdata[7:0];
                wlane_q      <= s_axi_wstrb[0];
                w_done_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= tcr_pkg::idx_known(aw_idx_q) ?
                                tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_done_q     <= 1'b0;
                w_done_q      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_st_q       <= tcr_pkg::RD_IDLE;
            s_axi_arready <= 1'b1;
            ar_idx_q      <= 8'h00;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= tcr_pkg::RESP_OKAY;
        end else begin
            case (rd_st_q)
                tcr_pkg::RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        ar_idx_q      <= s_axi_araddr[9:2];
                        s_axi_arready <= 1'b0;
                        rd_st_q       <= tcr_pkg::RD_FETCH;
                    end
                end
                tcr_pkg::RD_FETCH: begin
                    s_axi_rdata  <= {24'h000000, rd_data_i};
                    s_axi_rresp  <= tcr_pkg::idx_known(ar_idx_q) ?
                                    tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
                    s_axi_rvalid <= 1'b1;
                    rd_st_q      <= tcr_pkg::RD_RESP;
                end
                tcr_pkg::RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_st_q       <= tcr_pkg::RD_IDLE;
                    end
                end
                default: begin
                    rd_st_q <= tcr_pkg::RD_IDLE;
                end
            endcase
        end
    end
endmodule

// File: hdl/tcr_pkg.sv
/*
 * shared constants, types and helpers for the timer capture/compare
 * register block.
 * assumes a 32-bit axi4-lite slave with byte registers in the low lane.
 */
package tcr_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CAP_LO  = 8'h22;
    localparam logic [7:0] IDX_CAP_HI  = 8'h23;
    localparam logic [7:0] IDX_CMPB_LO = 8'h24;
    localparam logic [7:0] IDX_CMPB_HI = 8'h25;
    localparam logic [7:0] IDX_FLAGS   = 8'h2a;
    localparam logic [7:0] IDX_EN      = 8'h2b;
    localparam logic [7:0] IDX_SYNC    = 8'h2c;
    localparam logic [7:0] IDX_EVT     = 8'h30;
    localparam logic [7:0] IDX_MASK    = 8'h31;

    // bit positions in flag, enable, event and mask bytes
    localparam int BIT_CAP  = 5;
    localparam int BIT_B    = 2;
    localparam int BIT_A    = 1;
    localparam int BIT_WRAP = 0;

    // bit positions in the sync control byte
    localparam int SYNC_BIT  = 7;
    localparam int RELOC_BIT = 1;
    localparam int CLR_BIT   = 0;

    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0]  RST_SRC  = 4'h0;

    // waveform modes
    localparam logic [3:0]  MODE_NORMAL  = 4'h0;
    localparam logic [3:0]  MODE_CLR_A   = 4'h4;
    localparam logic [3:0]  MODE_CLR_CAP = 4'hc;
    localparam logic [15:0] COUNT_MAX    = 16'hffff;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // internal source order: {capture, match b, match a, wrap}
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] idx;
        logic [7:0] wdata;
    } tcr_req_t;

    typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} tcr_rd_state_t;

    function automatic logic [7:0] src_to_byte(input logic [3:0] s);
        logic [7:0] b;
        b = 8'h00;
        b[BIT_CAP]  = s[3];
        b[BIT_B]    = s[2];
        b[BIT_A]    = s[1];
        b[BIT_WRAP] = s[0];
        return b;
    endfunction

    function automatic logic [3:0] byte_to_src(input logic [7:0] b);
        return {b[BIT_CAP], b[BIT_B], b[BIT_A], b[BIT_WRAP]};
    endfunction

    function automatic logic idx_known(input logic [7:0] i);
        return i == IDX_CAP_LO || i == IDX_CAP_HI || i == IDX_CMPB_LO ||
               i == IDX_CMPB_HI || i == IDX_FLAGS || i == IDX_EN ||
               i == IDX_SYNC || i == IDX_EVT || i == IDX_MASK;
    endfunction

    function automatic logic uses_capture_top(input logic [3:0] m);
        return m == 4'h8 || m == 4'ha || m == MODE_CLR_CAP || m == 4'he;
    endfunction

endpackage

// File: hdl/tcr_sticky.sv
/*
 * bank of sticky bits: hardware set wins over any clear in the same cycle.
 * assumes set and clear are single-cycle qualified pulses.
 */
`timescale 1ns/1ps
module tcr_sticky (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // set and clear
    input  wire logic [3:0] set_i,
    input  wire logic [3:0] clr_i,
    // state
    output logic      [3:0] bits_q
);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bits_q <= tcr_pkg::RST_SRC;
        end else begin
            bits_q <= set_i | (bits_q & ~clr_i);
        end
    end
endmodule

// File: hdl/tcr_top.sv
/*
 * register part of a 16-bit timer: compare b value, capture value,
 * interrupt enables and flags, sync control, plus an event/mask
 * interrupt pair. the counter core and waveform unit sit outside and
 * hand over counter value, tick, mode and forced strobes.
 * assumes all inputs are synchronous to core_clk.
 */
// What this block does
// RULE_01: compare b is two byte registers, low at base, high at base+1.
// RULE_02: compare b is checked against the counter on each timer tick.
// RULE_03: a capture event copies the counter; source is pin or comparator.
// RULE_04: in capture-top modes the capture register gives the counter top.
// RULE_05: enables at bits 5,2,1,0; request needs enable, flag, global enable.
// RULE_06: flags sit at the same bit positions as their enables.
// RULE_07: capture flag on capture event, or on reaching top in top mode.
// RULE_08: match flags set on the tick after the counter equals compare.
// RULE_09: forced match strobes drive outputs but set no flag.
// RULE_10: wrap flag on overflow in normal and clr modes, else per mode.
// RULE_11: flags clear on vector execution or on a written one.
// RULE_12: prescaler clear bit resets prescaler and self-clears unless sync.
// RULE_13: in sync mode the prescaler clear value is kept, counter halted.
// RULE_14: writing sync mode zero clears prescaler clear, counting resumes.
// RULE_15: relocate bit picks the default or alternate timer pin set.
// RULE_16: unused bits of enables and flags read zero and ignore writes.
`timescale 1ns/1ps
module tcr_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // axi4-lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic  [3:0] s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic       [1:0] s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic       [1:0] s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // counter core
    input  wire logic        timer_tick,
    input  wire logic [15:0] counter_value,
    input  wire logic  [3:0] waveform_mode_sel,
    input  wire logic [15:0] compare_a_value,
    input  wire logic        core_wrap_evt,
    input  wire logic        force_match_a,
    input  wire logic        force_match_b,
    // capture sources
    input  wire logic        capture_pin_dflt,
    input  wire logic        capture_pin_alt,
    input  wire logic        comparator_out,
    input  wire logic        comparator_capture_sel,
    // cpu interrupt side
    input  wire logic        global_irq_en,
    input  wire logic  [3:0] vector_ack,
    // outputs to core, waveform unit and cpu
    output logic             prescaler_reset_q,
    output logic             pin_relocate_q,
    output logic             top_from_capture_q,
    output logic      [15:0] top_value_q,
    output logic      [15:0] capture_value_q,
    output logic             match_a_out_q,
    output logic             match_b_out_q,
    output logic       [3:0] irq_req_q,
    output logic             irq_q
);
    tcr_pkg::tcr_req_t req;
    logic [7:0]        rd_data;

    logic [15:0] compare_b_value_q;
    logic  [3:0] enables_q;
    logic  [3:0] evt_mask_q;
    logic        sync_hold_mode_q;
    logic        prescaler_clear_q;

    logic        match_a_pend_q;
    logic        match_b_pend_q;
    logic        cap_src_prev_q;

    logic  [3:0] flags;
    logic  [3:0] evt_status;
    logic  [3:0] src_set;
    logic  [3:0] flag_clr;
    logic  [3:0] evt_clr;

    logic        cap_src;
    logic        cap_edge;
    logic        cap_top;
    logic        cap_take;
    logic        set_cap;
    logic        set_a;
    logic        set_b;
    logic        set_wrap;
    logic        wr_sync;

    tcr_axil_slave u_bus (
        .core_clk      (core_clk),
        .arst_n        (arst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .req_o         (req),
        .rd_data_i     (rd_data)
    );

    // capture source selection and edge
    assign cap_src  = comparator_capture_sel ? comparator_out :      // [RULE_03]
                      pin_relocate_q ? capture_pin_alt :             // [RULE_15]
                      capture_pin_dflt;
    assign cap_edge = cap_src && !cap_src_prev_q;
    assign cap_top  = tcr_pkg::uses_capture_top(waveform_mode_sel);
    assign cap_take = cap_edge && !cap_top;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_src_prev_q <= 1'b0;
        end else begin
            cap_src_prev_q <= cap_src;
        end
    end

    // flag set conditions
    assign set_cap  = cap_top ?
                      (timer_tick && counter_value == capture_value_q) :
                      cap_edge;                                      // [RULE_07]
    assign set_a    = timer_tick && match_a_pend_q;                  // [RULE_08]
    assign set_b    = timer_tick && match_b_pend_q;                  // [RULE_08]
    assign set_wrap = (waveform_mode_sel == tcr_pkg::MODE_NORMAL ||
                       waveform_mode_sel == tcr_pkg::MODE_CLR_A ||
                       waveform_mode_sel == tcr_pkg::MODE_CLR_CAP) ?
                      (timer_tick &&
                       counter_value == tcr_pkg::COUNT_MAX) :
                      core_wrap_evt;                                 // [RULE_10]
    // forced strobes are kept out of src_set
    assign src_set  = {set_cap, set_b, set_a, set_wrap};             // [RULE_09]

    // match found on one tick, flagged on the next
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            match_a_pend_q <= 1'b0;
            match_b_pend_q <= 1'b0;
        end else if (timer_tick) begin
            match_a_pend_q <= counter_value == compare_a_value;
            match_b_pend_q <= counter_value == compare_b_value_q;    // [RULE_02]
        end
    end

    // waveform strobes: real match or forced
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            match_a_out_q <= 1'b0;
            match_b_out_q <= 1'b0;
        end else begin
            match_a_out_q <= set_a || force_match_a;                 // [RULE_09]
            match_b_out_q <= set_b || force_match_b;                 // [RULE_09]
        end
    end

    // flag clears: vector ack or written one
    assign flag_clr = vector_ack |
                      ((req.wr && req.idx == tcr_pkg::IDX_FLAGS) ?
                       tcr_pkg::byte_to_src(req.wdata) : 4'h0);     // [RULE_11]
    assign evt_clr  = (req.rd && req.idx == tcr_pkg::IDX_EVT) ?
                      4'hf : 4'h0;

    tcr_sticky u_flags (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .set_i    (src_set),
        .clr_i    (flag_clr),
        .bits_q   (flags)
    );

    tcr_sticky u_events (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .set_i    (src_set),
        .clr_i    (evt_clr),
        .bits_q   (evt_status)
    );

    // compare b value, byte wide halves
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            compare_b_value_q <= tcr_pkg::RST_WORD;
        end else if (req.wr) begin
            if (req.idx == tcr_pkg::IDX_CMPB_LO) begin
                compare_b_value_q[7:0] <= req.wdata;                 // [RULE_01]
            end
            if (req.idx == tcr_pkg::IDX_CMPB_HI) begin
                compare_b_value_q[15:8] <= req.wdata;                // [RULE_01]
            end
        end
    end

    // capture value: hardware capture beats a software write
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            capture_value_q <= tcr_pkg::RST_WORD;
        end else if (cap_take) begin
            capture_value_q <= counter_value;                        // [RULE_03]
        end else if (req.wr && req.idx == tcr_pkg::IDX_CAP_LO) begin
            capture_value_q[7:0] <= req.wdata;
        end else if (req.wr && req.idx == tcr_pkg::IDX_CAP_HI) begin
            capture_value_q[15:8] <= req.wdata;
        end
    end

    // top value handed to the counter core
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            top_from_capture_q <= 1'b0;
            top_value_q        <= tcr_pkg::COUNT_MAX;
        end else begin
            top_from_capture_q <= cap_top;                           // [RULE_04]
            top_value_q        <= cap_top ? capture_value_q :
                                  tcr_pkg::COUNT_MAX;                // [RULE_04]
        end
    end

    // enables and event mask
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            enables_q  <= tcr_pkg::RST_SRC;
            evt_mask_q <= tcr_pkg::RST_SRC;
        end else if (req.wr) begin
            if (req.idx == tcr_pkg::IDX_EN) begin
                enables_q <= tcr_pkg::byte_to_src(req.wdata);        // [RULE_16]
            end
            if (req.idx == tcr_pkg::IDX_MASK) begin
                evt_mask_q <= tcr_pkg::byte_to_src(req.wdata);
            end
        end
    end

    // sync control: hold mode, relocate, prescaler clear
    assign wr_sync = req.wr && req.idx == tcr_pkg::IDX_SYNC;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_hold_mode_q  <= 1'b0;
            pin_relocate_q    <= 1'b0;
            prescaler_clear_q <= 1'b0;
        end else if (wr_sync) begin
            sync_hold_mode_q  <= req.wdata[tcr_pkg::SYNC_BIT];
            pin_relocate_q    <= req.wdata[tcr_pkg::RELOC_BIT];      // [RULE_15]
            // kept only when hold mode is on after this write
            prescaler_clear_q <= req.wdata[tcr_pkg::CLR_BIT] &&
                                 req.wdata[tcr_pkg::SYNC_BIT];       // [RULE_14]
        end else if (!sync_hold_mode_q) begin
            prescaler_clear_q <= 1'b0;                               // [RULE_12]
        end
    end

    // prescaler reset: one pulse per write of the clear bit, held through hold mode
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prescaler_reset_q <= 1'b0;
        end else if (wr_sync) begin
            prescaler_reset_q <= req.wdata[tcr_pkg::CLR_BIT];        // [RULE_12]
        end else begin
            prescaler_reset_q <= prescaler_clear_q &&
                                 sync_hold_mode_q;                   // [RULE_13]
        end
    end

    // interrupt requests and summary line
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_req_q <= tcr_pkg::RST_SRC;
            irq_q     <= 1'b0;
        end else begin
            irq_req_q <= flags & enables_q &
                         {4{global_irq_en}};                         // [RULE_05]
            irq_q     <= |(evt_status & evt_mask_q);
        end
    end

    // read back, unused bits read zero
    always_comb begin
        case (req.idx)
            tcr_pkg::IDX_CAP_LO:  rd_data = capture_value_q[7:0];
            tcr_pkg::IDX_CAP_HI:  rd_data = capture_value_q[15:8];
            tcr_pkg::IDX_CMPB_LO: rd_data = compare_b_value_q[7:0];
            tcr_pkg::IDX_CMPB_HI: rd_data = compare_b_value_q[15:8];
            tcr_pkg::IDX_FLAGS:
                rd_data = tcr_pkg::src_to_byte(flags);               // [RULE_06]
            tcr_pkg::IDX_EN:
                rd_data = tcr_pkg::src_to_byte(enables_q);           // [RULE_05]
            tcr_pkg::IDX_EVT:
                rd_data = tcr_pkg::src_to_byte(evt_status);
            tcr_pkg::IDX_MASK:
                rd_data = tcr_pkg::src_to_byte(evt_mask_q);
            tcr_pkg::IDX_SYNC: begin
                rd_data = 8'h00;
                rd_data[tcr_pkg::SYNC_BIT]  = sync_hold_mode_q;
                rd_data[tcr_pkg::RELOC_BIT] = pin_relocate_q;
                rd_data[tcr_pkg::CLR_BIT]   = prescaler_clear_q;
            end
            default: rd_data = 8'h00;
        endcase
    end

endmodule

// File: sim/tb.sv
/* self-checking bench for tcr_top through its axi4-lite port and its timer-side ports.
   assumes answers inside the ceiling. */
`timescale 1ns/1ps
module tb;
    logic        core_clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, waveform_mode_sel = 4'h0, vector_ack = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, timer_tick = 0, core_wrap_evt = 0;
    logic        force_match_a = 0, force_match_b = 0, capture_pin_dflt = 0;
    logic        capture_pin_alt = 0, comparator_out = 0;
    logic        comparator_capture_sel = 0, global_irq_en = 1;
    logic        prescaler_reset_q, pin_relocate_q, top_from_capture_q;
    logic        match_a_out_q, match_b_out_q, irq_q;
    logic [15:0] counter_value = 16'h0, compare_a_value = 16'h1234;
    logic [15:0] top_value_q, capture_value_q;
    logic [3:0]  irq_req_q;
    int          n_mismatch = 0, samples_checked = 0, cyc = 0;
    tcr_top DUT (.*);
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic w(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(logic [7:0] i, logic [7:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task automatic rd(logic [7:0] i, logic [7:0] e, logic [1:0] rs = 2'h0);
        @(posedge core_clk);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        chk("rdata", s_axi_rdata, {24'h0, e});
        chk("rresp", s_axi_rresp, rs);
    endtask
    task automatic tick(logic [15:0] c);
        @(posedge core_clk);
        counter_value <= c;
        timer_tick <= 1;
        @(posedge core_clk);
        timer_tick <= 0;
    endtask
    task automatic t_regs();
        logic [7:0] ix [6] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h2a, 8'h2b};
        for (int k = 0; k < 6; k++) rd(ix[k], 8'h00);
        wr(8'h24, 8'h34);
        wr(8'h25, 8'h12);
        rd(8'h24, 8'h34);
        rd(8'h25, 8'h12);
        wr(8'h2b, 8'hff);
        rd(8'h2b, 8'h27);
        rd(8'h40, 8'h00, 2'h2);
    endtask
    task automatic t_cap();
        wr(8'h31, 8'h20);
        counter_value <= 16'hbeef;
        capture_pin_dflt <= 1;
        w(3);
        chk("irq", irq_q, 1);
        chk("req", irq_req_q, 4'h8);
        chk("cap", capture_value_q, 16'hbeef);
        rd(8'h23, 8'hbe);
        rd(8'h2a, 8'h20);
        rd(8'h30, 8'h20);
        w(2);
        chk("irq", irq_q, 0);
        capture_pin_dflt <= 0;
        vector_ack <= 4'h8;
        w(1);
        vector_ack <= 4'h0;
        rd(8'h2a, 8'h00);
    endtask
    task automatic t_match();
        tick(16'h1234);
        w(2);
        chk("req", irq_req_q, 4'h0);
        tick(16'h1235);
        w(2);
        chk("req", irq_req_q, 4'h6);
        rd(8'h2a, 8'h06);
        wr(8'h2a, 8'h02);
        rd(8'h2a, 8'h04);
        global_irq_en <= 0;
        w(2);
        chk("req", irq_req_q, 4'h0);
        global_irq_en <= 1;
        vector_ack <= 4'h4;
        force_match_a <= 1;
        force_match_b <= 1;
        w(2);
        chk("fo", {match_a_out_q, match_b_out_q}, 3);
        vector_ack <= 4'h0;
        force_match_a <= 0;
        force_match_b <= 0;
        rd(8'h2a, 8'h00);
    endtask
    task automatic t_wrap();
        core_wrap_evt <= 1;
        w(1);
        core_wrap_evt <= 0;
        tick(16'hffff);
        rd(8'h2a, 8'h01);
        wr(8'h2a, 8'hff);
        rd(8'h2a, 8'h00);
    endtask
    task automatic t_sync();
        wr(8'h2c, 8'h81);
        w(2);
        chk("pre", prescaler_reset_q, 1);
        wr(8'h2c, 8'h00);
        w(2);
        chk("pre", prescaler_reset_q, 0);
        wr(8'h2c, 8'h03);
        w(2);
        chk("pre", prescaler_reset_q, 0);
        chk("reloc", pin_relocate_q, 1);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1;
        t_regs();
        t_cap();
        t_match();
        t_wrap();
        t_sync();
        summarize();
    end
endmodule

// File: sim/tcr_chk.sv
/* checker on tcr_top ports.
   assumes it is bound to every tcr_top instance. */
`timescale 1ns/1ps
module tcr_chk (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // bus
    input wire logic        s_axi_awvalid, s_axi_awready,
    input wire logic        s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready,
    input wire logic        s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // timer side
    input wire logic  [3:0] irq_req_q,
    input wire logic        global_irq_en, top_from_capture_q,
    input wire logic [15:0] top_value_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("b late");
    a_b_blocks: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("aw taken during b");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("bvalid dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |->
        ##2 s_axi_rvalid) else $error("r late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r changed");
    a_rdata_low: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h0) else $error("upper rdata set");
    a_irq_gate: assert property (|irq_req_q |->
        $past(global_irq_en)) else $error("request without global enable");
    a_top_dflt: assert property (!top_from_capture_q &&
        $past(!top_from_capture_q) |-> top_value_q == 16'hffff)
        else $error("top not full count");
endmodule
bind tcr_top tcr_chk u_chk (.*);
